// *** hdl/ethernet_event_interrupt_unit.sv ***
// Event flag, enable and interrupt pin logic of the Ethernet controller
`timescale 1ns/10ps

module ethernet_event_interrupt_unit
    import event_irq_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    input  wire host_req_t           hostReq,
    output logic [DATA_W-1:0]        rdData,
    input  wire engine_evt_t         evt,
    input  wire logic                linkUp,
    input  wire logic [DATA_W-1:0]   txStatusIn,
    output logic                     intPinN,
    output logic                     cryptoPowerEnable,
    output logic                     txRequest
);

    logic [DATA_W-1:0]  flag;
    logic [DATA_W-1:0]  enable;
    logic [DATA_W-1:0]  txStatusReg;
    logic [COUNT_W-1:0] count;
    logic               linkPrev;
    logic               statusInt;

    logic [DATA_W-1:0]  next_flag;
    logic [DATA_W-1:0]  next_enable;
    logic [COUNT_W-1:0] next_count;
    logic               next_txRequest;
    logic [DATA_W-1:0]  hwSet;
    logic [DATA_W-1:0]  ctrlNew;
    logic [DATA_W-1:0]  ctrlNow;
    logic [DATA_W-1:0]  statusRead;
    logic               pendingNext;
    logic               txEnd;
    logic               swAbort;
    logic               inc;
    logic               dec;
    logic               drop;

    // Host operation aimed at one register, idle for all others
    function automatic host_op_t op_for(input logic [SEL_W-1:0] sel);
        return (hostReq.sel == sel) ? hostReq.op : OP_IDLE;
    endfunction : op_for

    // Write, set and clear all touch only the bits in mask
    function automatic logic [DATA_W-1:0] apply_op(
        input logic [DATA_W-1:0] old,
        input host_op_t          op,
        input logic [DATA_W-1:0] data,
        input logic [DATA_W-1:0] mask
    );
        case (op)
            OP_WRITE: return (old & ~mask) | (data & mask);
            OP_SET:   return old | (data & mask);
            OP_CLEAR: return old & ~(data & mask);
            default:  return old;
        endcase
    endfunction : apply_op

    // Control register: request bit stored, decrement bit self-clearing
    always_comb begin
        ctrlNow = '0;
        ctrlNow[CTRL_TXREQ] = txRequest;
        ctrlNew = apply_op(ctrlNow, op_for(SEL_CONTROL), hostReq.data,
                           CTRL_WRITABLE);
    end

    assign txEnd = evt.txDone | evt.txAbort;
    // Host dropping the request by hand counts as an abort
    assign swAbort = txRequest & ~ctrlNew[CTRL_TXREQ] & ~txEnd;

    // A fresh host request wins over an end reported in the same cycle
    always_comb begin
        if (ctrlNew[CTRL_TXREQ] && !txRequest) begin
            next_txRequest = 1'b1;
        end else if (txEnd) begin
            next_txRequest = 1'b0;
        end else begin
            next_txRequest = ctrlNew[CTRL_TXREQ];
        end
    end

    // Packet counter; a packet arriving at the maximum is dropped
    always_comb begin
        dec  = ctrlNew[CTRL_DEC] && (count != COUNT_ZERO);
        inc  = evt.rxPacket && (count != COUNT_MAX);
        drop = evt.rxPacket && (count == COUNT_MAX);
        next_count = count + COUNT_W'(inc) - COUNT_W'(dec);
    end

    // Hardware events; a set always beats a host clear in the same cycle
    always_comb begin
        hwSet = '0;
        hwSet[BIT_MODEXP]  = evt.modexpDone;
        hwSet[BIT_HASH]    = evt.hashDone;
        hwSet[BIT_CIPHER]  = evt.blockCipherDone;
        hwSet[BIT_LINK]    = linkUp != linkPrev;
        hwSet[BIT_DMA]     = evt.dmaDone;
        hwSet[BIT_TXDONE]  = txEnd | swAbort;
        hwSet[BIT_TXABORT] = evt.txAbort | swAbort;
        hwSet[BIT_RXABORT] = drop | evt.rxNoSpace;
        hwSet[BIT_FULL]    = (next_count == COUNT_MAX)
                             && (count != COUNT_MAX);
    end

    always_comb begin
        next_flag = apply_op(flag, op_for(SEL_FLAG), hostReq.data,
                             FLAG_WRITABLE);
        if (dec) begin
            next_flag[BIT_FULL] = 1'b0;
        end
        next_flag = next_flag | hwSet;
        next_flag[BIT_PENDING] = next_count != COUNT_ZERO;
        next_enable = apply_op(enable, op_for(SEL_ENABLE), hostReq.data,
                               ENABLE_WRITABLE);
        // Crypto enable shares bit 15 but is kept out of the sources
        pendingNext = |(next_flag & next_enable & FLAG_SOURCES);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= FLAG_RESET;
        end else if (ce) begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable <= ENABLE_RESET;
        end else if (ce) begin
            enable <= next_enable;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= COUNT_ZERO;
        end else if (ce) begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txRequest <= 1'b0;
            txStatusReg <= TX_STATUS_RESET;
        end else if (ce) begin
            txRequest <= next_txRequest;
            if (evt.txAbort) begin
                txStatusReg <= txStatusIn;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            linkPrev <= 1'b0;
        end else if (ce) begin
            linkPrev <= linkUp;
        end
    end

    // Pin and status follow the next values so they move with the flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            statusInt <= 1'b0;
            intPinN <= 1'b1;
        end else if (ce) begin
            statusInt <= pendingNext;
            // Pin rises when the global enable drops while a source is pending; re-enable then falls
            intPinN <= ~(pendingNext
                         & next_enable[BIT_GLOBAL]);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cryptoPowerEnable <= 1'b0;
        end else if (ce) begin
            cryptoPowerEnable <= next_flag[BIT_CRYPTO];
        end
    end

    always_comb begin
        statusRead = '0;
        statusRead[STATUS_INT]  = statusInt;
        statusRead[STATUS_LINK] = linkPrev;
        statusRead[COUNT_W-1:0] = count;
    end

    // Read data holds until the next read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= '0;
        end else if (ce && hostReq.op == OP_READ) begin
            case (hostReq.sel)
                SEL_FLAG:      rdData <= flag & FLAG_READABLE;
                SEL_ENABLE:    rdData <= enable;
                SEL_STATUS:    rdData <= statusRead;
                SEL_CONTROL:   rdData <= ctrlNow;
                SEL_TX_STATUS: rdData <= txStatusReg;
                default:       rdData <= '0;
            endcase
        end
    end

    a_pin_level: assert property (
        @(posedge clk) disable iff (!rstn)
        intPinN == !(statusInt && enable[BIT_GLOBAL]))
        else $error("interrupt pin disagrees with status and enable");

    a_global_off: assert property (
        @(posedge clk) disable iff (!rstn)
        !enable[BIT_GLOBAL] |-> intPinN)
        else $error("pin low while global enable clear");

    a_pin_holds: assert property (
        @(posedge clk) disable iff (!rstn)
        !intPinN && ce && hostReq.op == OP_IDLE |=> !intPinN)
        else $error("pin released without a clear or mask");

    a_rearm_edge: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(enable[BIT_GLOBAL]) && statusInt |-> !intPinN && $past(intPinN))
        else $error("no fresh falling edge on re-enable");

    a_status_merge: assert property (
        @(posedge clk) disable iff (!rstn)
        statusInt == |(flag & enable & FLAG_SOURCES))
        else $error("status bit does not match enabled flags");

    a_flag_unmasked: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.dmaDone && !enable[BIT_DMA] |=> flag[BIT_DMA])
        else $error("masked dma event lost");

    a_engine_flags: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.modexpDone && evt.hashDone && evt.blockCipherDone
        |=> flag[BIT_MODEXP] && flag[BIT_HASH] && flag[BIT_CIPHER])
        else $error("engine done event not flagged");

    a_hash_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.hashDone |=> flag[BIT_HASH])
        else $error("hash done not flagged");

    a_link_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && linkUp != linkPrev
        |=> flag[BIT_LINK] && linkPrev == $past(linkUp))
        else $error("link change not flagged");

    a_pending_count: assert property (
        @(posedge clk) disable iff (!rstn)
        flag[BIT_PENDING] == (count != COUNT_ZERO))
        else $error("pending flag does not track packet count");

    a_tx_done: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.txDone && hostReq.op == OP_IDLE
        |=> !txRequest && flag[BIT_TXDONE])
        else $error("transmit completion not handled");

    a_tx_abort: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.txAbort
        |=> flag[BIT_TXABORT] && txStatusReg == $past(txStatusIn))
        else $error("transmit abort not handled");

    a_rx_drop: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.rxPacket && count == COUNT_MAX |=> flag[BIT_RXABORT])
        else $error("dropped packet not flagged");

    a_count_full: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && inc && !dec && count == COUNT_MAX - 8'h01
        |=> flag[BIT_FULL] && count == COUNT_MAX)
        else $error("count full not flagged");

    a_crypto_out: assert property (
        @(posedge clk) disable iff (!rstn)
        cryptoPowerEnable == flag[BIT_CRYPTO])
        else $error("crypto power enable differs from flag bit");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        (flag & ~FLAG_READABLE) == '0)
        else $error("reserved flag bit became set");

    a_modexp_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.modexpDone |=> flag[BIT_MODEXP])
        else $error("modular exponentiation done not flagged");

    a_cipher_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.blockCipherDone |=> flag[BIT_CIPHER])
        else $error("block cipher done not flagged");

    a_dma_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && evt.dmaDone |=> flag[BIT_DMA])
        else $error("dma done not flagged");

    a_full_clear: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && dec && count == COUNT_MAX |=> !flag[BIT_FULL])
        else $error("count full kept after decrement");

    // Frozen cycles must not move anything the host can see
    a_ce_freeze: assert property (
        @(posedge clk) disable iff (!rstn)
        !ce |=> $stable(flag) && $stable(intPinN) && $stable(rdData))
        else $error("state moved while clock enable low");

endmodule : ethernet_event_interrupt_unit

// *** hdl/event_irq_pkg.sv ***
// Package: register map, field layout and carriers of the event interrupt unit
package event_irq_pkg;

    localparam int DATA_W = 16;
    localparam int SEL_W  = 4;
    localparam int COUNT_W = 8;

    // Register selectors on the host register port
    localparam logic [SEL_W-1:0] SEL_FLAG      = 4'h0;
    localparam logic [SEL_W-1:0] SEL_ENABLE    = 4'h1;
    localparam logic [SEL_W-1:0] SEL_STATUS    = 4'h2;
    localparam logic [SEL_W-1:0] SEL_CONTROL   = 4'h3;
    localparam logic [SEL_W-1:0] SEL_TX_STATUS = 4'h4;

    // Flag and enable bit positions (enable bits mirror the flags, except bit 15: crypto flag, global enable)
    localparam int BIT_CRYPTO   = 15;
    localparam int BIT_GLOBAL   = 15;
    localparam int BIT_MODEXP   = 14;
    localparam int BIT_HASH     = 13;
    localparam int BIT_CIPHER   = 12;
    localparam int BIT_LINK     = 11;
    localparam int BIT_PENDING  = 6;
    localparam int BIT_DMA      = 5;
    localparam int BIT_TXDONE   = 3;
    localparam int BIT_TXABORT  = 2;
    localparam int BIT_RXABORT  = 1;
    localparam int BIT_FULL     = 0;

    // Status and control bit positions
    localparam int STATUS_INT   = 15;
    localparam int STATUS_LINK  = 8;
    localparam int CTRL_DEC     = 8;
    localparam int CTRL_TXREQ   = 1;

    localparam logic [DATA_W-1:0] FLAG_RESET      = 16'h0800;
    localparam logic [DATA_W-1:0] ENABLE_RESET    = 16'h8010;
    localparam logic [DATA_W-1:0] FLAG_WRITABLE   = 16'hf82f;
    localparam logic [DATA_W-1:0] FLAG_SOURCES    = 16'h786f;
    localparam logic [DATA_W-1:0] FLAG_READABLE   = 16'hf86f;
    localparam logic [DATA_W-1:0] ENABLE_WRITABLE = 16'hf86f;
    localparam logic [DATA_W-1:0] CTRL_WRITABLE   = 16'h0102;
    localparam logic [DATA_W-1:0] TX_STATUS_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX      = 8'hff;
    localparam logic [COUNT_W-1:0] COUNT_ZERO     = 8'h00;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE,
        OP_SET,
        OP_CLEAR
    } host_op_t;

    typedef struct packed {
        host_op_t               op;
        logic [SEL_W-1:0]       sel;
        logic [DATA_W-1:0]      data;
    } host_req_t;

    typedef struct packed {
        logic modexpDone;
        logic hashDone;
        logic blockCipherDone;
        logic dmaDone;
        logic txDone;
        logic txAbort;
        logic rxPacket;
        logic rxNoSpace;
    } engine_evt_t;

endpackage : event_irq_pkg

// *** dv/host_irq_model.sv ***
// Host-side model that senses falling edges on the interrupt pin
`timescale 1ns/10ps

module host_irq_model (
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  intPinN,
    output logic [7:0] edgeCount
);
    logic pinPrev;

    // Sampled edge detect: a host on the same clock misses sub-cycle glitches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinPrev   <= 1'b1;
            edgeCount <= 8'h00;
        end else begin
            pinPrev <= intPinN;
            if (pinPrev && !intPinN) begin
                edgeCount <= edgeCount + 8'h01;
            end
        end
    end
endmodule : host_irq_model

// *** dv/tb_top.sv ***
// Self-checking bench of the event interrupt unit
`timescale 1ns/10ps

module tb_top;
    import event_irq_pkg::*;

    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              ce = 1'b1;
    host_req_t         hostReq = '{OP_IDLE, 4'h0, 16'h0000};
    engine_evt_t       evt = '0;
    logic              linkUp = 1'b0;
    logic [DATA_W-1:0] txStatusIn = 16'h0000;
    logic [DATA_W-1:0] rdData;
    logic              intPinN;
    logic              cryptoPowerEnable;
    logic              txRequest;
    logic [7:0]        edgeCount;
    logic [DATA_W-1:0] v;
    int                fail_count = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    ethernet_event_interrupt_unit u_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .hostReq(hostReq), .rdData(rdData), .evt(evt), .linkUp(linkUp),
        .txStatusIn(txStatusIn), .intPinN(intPinN),
        .cryptoPowerEnable(cryptoPowerEnable), .txRequest(txRequest));

    host_irq_model u_host (.clk(clk), .rstn(rstn), .intPinN(intPinN),
        .edgeCount(edgeCount));

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [DATA_W-1:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One host operation; effects are settled when this returns
    task automatic hop(input host_op_t o, input logic [SEL_W-1:0] s,
                       input logic [DATA_W-1:0] d);
        @(posedge clk);
        hostReq <= '{o, s, d};
        @(posedge clk);
        hostReq <= '{OP_IDLE, s, d};
        #1;
    endtask : hop

    task automatic rd(input logic [SEL_W-1:0] s);
        hop(OP_READ, s, 16'h0000);
        v = rdData;
    endtask : rd

    task automatic pulse(input engine_evt_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        #1;
    endtask : pulse

    task automatic t_reset();
        chk({15'h0, intPinN}, 16'h0001, "pin idle");
        rd(SEL_FLAG);
        chk(v, 16'h0800, "flag reset");
        rd(SEL_ENABLE);
        chk(v, 16'h8010, "enable reset");
        rd(SEL_STATUS);
        chk(v, 16'h0000, "status reset");
        rd(4'h5);
        chk(v, 16'h0000, "unmapped read");
        hop(OP_SET, SEL_FLAG, 16'h0790);
        rd(SEL_FLAG);
        chk(v, 16'h0800, "reserved set");
        hop(OP_CLEAR, SEL_ENABLE, 16'h0010);
        rd(SEL_ENABLE);
        chk(v, 16'h8010, "enable bit 4 fixed");
        hop(OP_CLEAR, SEL_FLAG, 16'h0800);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_flags();
        int eb[5] = '{7, 6, 5, 4, 0};
        int fb[5] = '{14, 13, 12, 5, 1};
        for (int i = 0; i < 5; i++) begin
            pulse(engine_evt_t'(8'h01 << eb[i]));
            chk({15'h0, intPinN}, 16'h0001, "masked pin");
            rd(SEL_FLAG);
            chk(v, 16'h0001 << fb[i], "event flag");
            hop(OP_CLEAR, SEL_FLAG, 16'h0001 << fb[i]);
        end
        // All three crypto engines finishing in one cycle
        pulse(engine_evt_t'(8'he0));
        rd(SEL_FLAG);
        chk(v, 16'h7000, "engine flags");
        hop(OP_CLEAR, SEL_FLAG, 16'h7000);
        $display("t_flags done");
    endtask : t_flags

    task automatic t_pin();
        hop(OP_SET, SEL_ENABLE, 16'h2000);
        pulse(engine_evt_t'(8'h40));
        chk({15'h0, intPinN}, 16'h0000, "pin asserted");
        rd(SEL_STATUS);
        chk(v & 16'h8000, 16'h8000, "status int");
        hop(OP_CLEAR, SEL_ENABLE, 16'h8000);
        chk({15'h0, intPinN}, 16'h0001, "global off");
        hop(OP_SET, SEL_ENABLE, 16'h8000);
        chk({15'h0, intPinN}, 16'h0000, "global on");
        rd(SEL_FLAG);
        chk({8'h00, edgeCount}, 16'h0002, "fresh edge");
        hop(OP_CLEAR, SEL_ENABLE, 16'h2000);
        chk({15'h0, intPinN}, 16'h0001, "masked off");
        hop(OP_SET, SEL_ENABLE, 16'h2000);
        chk({15'h0, intPinN}, 16'h0000, "unmasked");
        hop(OP_CLEAR, SEL_FLAG, 16'h2000);
        chk({15'h0, intPinN}, 16'h0001, "flag cleared");
        chk({8'h00, edgeCount}, 16'h0003, "edge count");
        $display("t_pin done");
    endtask : t_pin

    // Clock enable low swallows an event; nothing moves
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        pulse(engine_evt_t'(8'h40));
        chk({15'h0, intPinN}, 16'h0001, "frozen pin");
        @(posedge clk);
        ce <= 1'b1;
        rd(SEL_FLAG);
        chk(v, 16'h0000, "frozen flag");
        $display("t_freeze done");
    endtask : t_freeze

    task automatic t_crypto();
        hop(OP_SET, SEL_FLAG, 16'h8000);
        rd(SEL_FLAG);
        chk(v, 16'h8000, "crypto bit");
        chk({15'h0, cryptoPowerEnable}, 16'h0001, "power on");
        chk({15'h0, intPinN}, 16'h0001, "crypto no irq");
        rd(SEL_STATUS);
        chk(v & 16'h8000, 16'h0000, "crypto no status");
        hop(OP_CLEAR, SEL_FLAG, 16'h8000);
        rd(SEL_FLAG);
        chk({15'h0, cryptoPowerEnable}, 16'h0000, "power off");
        $display("t_crypto done");
    endtask : t_crypto

    task automatic t_link();
        @(posedge clk);
        linkUp <= 1'b1;
        rd(SEL_FLAG);
        chk(v, 16'h0800, "link flag");
        rd(SEL_STATUS);
        chk(v & 16'h0100, 16'h0100, "link state");
        hop(OP_CLEAR, SEL_FLAG, 16'h0800);
        @(posedge clk);
        linkUp <= 1'b0;
        rd(SEL_FLAG);
        chk(v, 16'h0800, "link drop flag");
        rd(SEL_STATUS);
        chk(v & 16'h0100, 16'h0000, "link down");
        hop(OP_CLEAR, SEL_FLAG, 16'h0800);
        $display("t_link done");
    endtask : t_link

    task automatic t_tx();
        hop(OP_SET, SEL_CONTROL, 16'h0002);
        chk({15'h0, txRequest}, 16'h0001, "tx request");
        pulse(engine_evt_t'(8'h08));
        chk({15'h0, txRequest}, 16'h0000, "tx done req");
        rd(SEL_FLAG);
        chk(v, 16'h0008, "tx done flag");
        hop(OP_SET, SEL_CONTROL, 16'h0002);
        @(posedge clk);
        txStatusIn <= 16'h0405;
        pulse(engine_evt_t'(8'h04));
        chk({15'h0, txRequest}, 16'h0000, "abort req");
        rd(SEL_FLAG);
        chk(v, 16'h000c, "abort flags");
        rd(SEL_TX_STATUS);
        chk(v, 16'h0405, "abort cause");
        hop(OP_CLEAR, SEL_FLAG, 16'h000c);
        // Host dropping the request by hand also ends the frame
        hop(OP_SET, SEL_CONTROL, 16'h0002);
        hop(OP_CLEAR, SEL_CONTROL, 16'h0002);
        chk({15'h0, txRequest}, 16'h0000, "host abort req");
        rd(SEL_FLAG);
        chk(v, 16'h000c, "host abort flags");
        hop(OP_CLEAR, SEL_FLAG, 16'h000c);
        $display("t_tx done");
    endtask : t_tx

    // Saturating packet count; the read-only pending bit resists a clear
    task automatic t_count();
        repeat (255) pulse(engine_evt_t'(8'h02));
        rd(SEL_FLAG);
        chk(v, 16'h0041, "count full");
        rd(SEL_STATUS);
        chk(v & 16'h00ff, 16'h00ff, "count max");
        pulse(engine_evt_t'(8'h02));
        hop(OP_CLEAR, SEL_FLAG, 16'h0040);
        rd(SEL_FLAG);
        chk(v, 16'h0043, "dropped packet");
        hop(OP_SET, SEL_CONTROL, 16'h0100);
        rd(SEL_FLAG);
        chk(v, 16'h0042, "full cleared");
        repeat (254) hop(OP_SET, SEL_CONTROL, 16'h0100);
        rd(SEL_FLAG);
        chk(v, 16'h0002, "pending cleared");
        $display("t_count done");
    endtask : t_count

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_flags();
        t_pin();
        t_freeze();
        t_crypto();
        t_link();
        t_tx();
        t_count();
        end_of_test();
    end
endmodule : tb_top
